// >>> rtl/lsos_pkg.sv
package lsos_pkg;
	localparam int CLK_HZ = 125_000_000; // System clock rate
	localparam int NCH = 8; // Channel count
	localparam logic [7:0] ON_RST = 8'h00; // On bits after reset
	localparam logic [15:0] FLT_RST = 16'h0000; // Faults after reset
	localparam logic [7:0] CFG_RST = 8'h00; // Control after reset
	localparam int CFG_TEN = 7; // Timer enable bit position
	localparam int CFG_DUTY_HI = 6; // Duty field top
	localparam int CFG_DUTY_LO = 4; // Duty field bottom
	localparam int CFG_TIME_HI = 3; // Time field top
	localparam int CFG_TIME_LO = 0; // Time field bottom
	localparam int FLT_OC_LO = 8; // Overcurrent flags start
	localparam int FLT_OL_LO = 0; // Open-load flags start
	localparam int PWM_HZ = 25_000; // Chopping frequency
	localparam int PWM_CYC = CLK_HZ / PWM_HZ; // Cycles per PWM period
	localparam int SLOT_CYC = PWM_CYC / 8; // Cycles per eighth
	localparam int MS_CYC = CLK_HZ / 1000; // Cycles per millisecond
	localparam logic [8:0] ENER_MS [16] = '{9'd0, 9'd3, 9'd5, 9'd10,
		9'd15, 9'd20, 9'd30, 9'd50, 9'd80, 9'd110, 9'd140, 9'd170,
		9'd200, 9'd230, 9'd260, 9'd300}; // Energize times in ms
	typedef enum logic [1:0] {LSOS_IDLE, LSOS_ENER, LSOS_CHOP,
		LSOS_HOLD} lsos_state_t;
endpackage

// >>> rtl/lsos_channel.sv
`timescale 1ns/1ps
`default_nettype none
// One output channel: energize phase, chopping phase, hold
module lsos_channel
	import lsos_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic ms_tick, // One pulse per millisecond
	input wire logic [2:0] pwm_slot, // Current eighth of PWM period
	input wire logic on_bit, // Channel on bit
	input wire logic [7:0] cfg, // Control register
	input wire logic pwm_start, // PWM start command strobe
	output logic drive // Channel gate drive
);
	lsos_state_t state_r; // Channel phase
	logic on_d_r; // Delayed on bit for edge detect
	logic [8:0] ms_left_r; // Energize milliseconds remaining
	logic [2:0] duty; // Chop duty code
	logic [3:0] tcode; // Energize time code
	logic expired; // Energize time has run out

	assign duty = cfg[CFG_DUTY_HI:CFG_DUTY_LO];
	assign tcode = cfg[CFG_TIME_HI:CFG_TIME_LO];
	assign expired = (ms_left_r == 9'h000);

	// Phase sequencing per channel
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= LSOS_IDLE;
			on_d_r <= 1'b0;
			ms_left_r <= 9'h000;
		end else begin
			on_d_r <= on_bit;
			if (!on_bit) begin
				state_r <= LSOS_IDLE;
			end else if (!on_d_r) begin
				ms_left_r <= ENER_MS[tcode];
				if (cfg[CFG_TEN] && tcode == 4'h0)
					state_r <= LSOS_CHOP;
				else
					state_r <= LSOS_ENER;
			end else begin
				case (state_r)
					LSOS_ENER: begin
						if (cfg[CFG_TEN]) begin
							if (pwm_start && !expired)
								state_r <= LSOS_CHOP;
							else if (expired)
								state_r <= LSOS_HOLD;
							else if (ms_tick)
								ms_left_r <= ms_left_r - 9'h001;
						end
					end
					LSOS_HOLD: begin
						if (!cfg[CFG_TEN])
							state_r <= LSOS_ENER;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Gate drive from phase
	always_comb begin
		case (state_r)
			LSOS_IDLE: drive = 1'b0;
			LSOS_CHOP: drive = cfg[CFG_TEN] ? (pwm_slot < duty) : 1'b1;
			LSOS_HOLD: drive = (duty != 3'h0) ? (pwm_slot < duty) : 1'b0;
			default: drive = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// >>> rtl/lsos_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Eight-channel low-side output sequencer with fault register
module lsos_sequencer
	import lsos_pkg::*;
#(
	parameter bit HAS_OPEN_LOAD = 1'b1 // Open-load detection present
)
(
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic data_wr, // Ordinary write strobe
	input wire logic [7:0] data_in, // Word shifted in
	input wire logic cfg_wr, // Write-control command strobe
	input wire logic cfg_rd, // Read-control command strobe
	input wire logic data_rd, // Data readback command strobe
	input wire logic fault_clr, // Fault reset command strobe
	input wire logic pwm_start, // PWM start command strobe
	input wire logic [7:0] oc_det, // Overcurrent detect per channel
	input wire logic [7:0] ol_det, // Open-load detect per channel
	input wire logic thermal_shutdown, // Die overtemperature
	output logic [7:0] chan_out, // Channel gate drives
	output logic fault_alarm_n, // Fault alarm, active low
	output logic [15:0] fault_flags, // Fault register view
	output logic [7:0] shift_load, // Word for serial shifter
	output logic shift_load_vld // Shifter load pulse
);
	logic [7:0] channel_on_bits_r; // Channel on bits
	logic [15:0] channel_fault_flags_r; // Fault flags
	logic [15:0] fault_nxt; // Next fault flags
	logic [7:0] drive_timing_config_r; // Control register
	logic [$clog2(SLOT_CYC)-1:0] slot_cnt_r; // Cycles in eighth
	logic [2:0] pwm_slot_r; // Eighth of PWM period
	logic [$clog2(MS_CYC)-1:0] ms_cnt_r; // Cycles in millisecond
	logic ms_tick_r; // Millisecond enable pulse
	logic [7:0] drive; // Raw channel drives

	// Channel on bits, written by ordinary writes
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			channel_on_bits_r <= ON_RST;
		else if (data_wr)
			channel_on_bits_r <= data_in;
	end

	// Control register, only via write-control command
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			drive_timing_config_r <= CFG_RST;
		else if (cfg_wr)
			drive_timing_config_r <= data_in;
	end

	// Fault flags: clears first, then detections win
	always_comb begin
		fault_nxt = channel_fault_flags_r;
		if (fault_clr)
			fault_nxt = 16'h0000;
		if (data_wr) begin
			fault_nxt[FLT_OL_LO +: 8] = fault_nxt[FLT_OL_LO +: 8]
				& ~data_in;
			fault_nxt[FLT_OC_LO +: 8] = fault_nxt[FLT_OC_LO +: 8]
				& data_in;
		end
		fault_nxt[FLT_OC_LO +: 8] = fault_nxt[FLT_OC_LO +: 8] | oc_det;
		if (HAS_OPEN_LOAD)
			fault_nxt[FLT_OL_LO +: 8] = fault_nxt[FLT_OL_LO +: 8]
				| ol_det;
	end

	// Fault register update
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			channel_fault_flags_r <= FLT_RST;
		else
			channel_fault_flags_r <= fault_nxt;
	end

	// Millisecond divider
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt_r <= '0;
			ms_tick_r <= 1'b0;
		end else begin
			ms_tick_r <= (ms_cnt_r == ($clog2(MS_CYC))'(MS_CYC - 1));
			if (ms_cnt_r == ($clog2(MS_CYC))'(MS_CYC - 1))
				ms_cnt_r <= '0;
			else
				ms_cnt_r <= ms_cnt_r + 1'b1;
		end
	end

	// PWM eighth-slot divider
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			slot_cnt_r <= '0;
			pwm_slot_r <= 3'h0;
		end else if (slot_cnt_r == ($clog2(SLOT_CYC))'(SLOT_CYC - 1)) begin
			slot_cnt_r <= '0;
			pwm_slot_r <= pwm_slot_r + 3'h1;
		end else begin
			slot_cnt_r <= slot_cnt_r + 1'b1;
		end
	end

	// One sequencer per channel
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		lsos_channel u_ch (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.ms_tick(ms_tick_r),
			.pwm_slot(pwm_slot_r),
			.on_bit(channel_on_bits_r[i]),
			.cfg(drive_timing_config_r),
			.pwm_start(pwm_start),
			.drive(drive[i])
		);
	end

	// Registered outputs, thermal shutdown gates drives
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			chan_out <= 8'h00;
			fault_alarm_n <= 1'b1;
			fault_flags <= 16'h0000;
		end else begin
			chan_out <= thermal_shutdown ? 8'h00 : drive;
			fault_alarm_n <= ~(|fault_nxt);
			fault_flags <= fault_nxt;
		end
	end

	// Readback loads for the serial shifter
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shift_load <= 8'h00;
			shift_load_vld <= 1'b0;
		end else begin
			shift_load_vld <= data_rd | cfg_rd;
			if (data_rd)
				shift_load <= channel_on_bits_r;
			else if (cfg_rd)
				shift_load <= drive_timing_config_r;
		end
	end

	// Assertions
	AST_TSD_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		thermal_shutdown |=> chan_out == 8'h00)
		else $error("output on during shutdown");
	AST_ALARM: assert property (@(posedge clk_sys) disable iff (!rst_b)
		|oc_det |=> !fault_alarm_n)
		else $error("alarm not raised");
	AST_OC_SET: assert property (@(posedge clk_sys) disable iff (!rst_b)
		oc_det[0] |=> channel_fault_flags_r[FLT_OC_LO])
		else $error("overcurrent flag not set");
	AST_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		fault_clr && !(|oc_det) && !(|ol_det) |=> channel_fault_flags_r == 16'h0)
		else $error("fault reset failed");
	AST_NO_OL: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!HAS_OPEN_LOAD |-> channel_fault_flags_r[7:0] == 8'h00)
		else $error("open-load flag in variant");
	AST_DATA_RB: assert property (@(posedge clk_sys) disable iff (!rst_b)
		data_rd |=> shift_load_vld && shift_load == $past(channel_on_bits_r))
		else $error("readback wrong");
	AST_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!cfg_wr |=> $stable(drive_timing_config_r))
		else $error("control changed without command");
	AST_FULL_ON: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!drive_timing_config_r[CFG_TEN] && channel_on_bits_r[0] && !data_wr
		##1 !drive_timing_config_r[CFG_TEN] && !thermal_shutdown
		|=> chan_out[0])
		else $error("channel not fully on");
	AST_OC_OFF_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		data_wr && !data_in[0] && !oc_det[0] |=> !channel_fault_flags_r[FLT_OC_LO])
		else $error("overcurrent flag not cleared");
	COV_PWM: cover property (@(posedge clk_sys) disable iff (!rst_b)
		pwm_start && drive_timing_config_r[CFG_TEN]);
	COV_TSD: cover property (@(posedge clk_sys) disable iff (!rst_b)
		thermal_shutdown ##1 !thermal_shutdown);
	COV_FAULT: cover property (@(posedge clk_sys) disable iff (!rst_b)
		!fault_alarm_n ##1 fault_clr);
endmodule
`default_nettype wire

// >>> sim/lsos_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller side: issues one command strobe per call
module lsos_host (
	input wire logic clk_sys, // System clock
	output logic data_wr, // Ordinary write strobe
	output logic cfg_wr, // Write-control strobe
	output logic cfg_rd, // Read-control strobe
	output logic data_rd, // Data readback strobe
	output logic fault_clr, // Fault reset strobe
	output logic pwm_start, // PWM start strobe
	output logic [7:0] data_in // Word sent
);
	// All strobes idle at time zero
	initial begin
		{data_wr, cfg_wr, cfg_rd, data_rd, fault_clr, pwm_start} = 6'h00;
		data_in = 8'h00;
	end
	// Strobe held over one sampling edge, then dropped; word turned over
	task automatic send(input logic [5:0] stb, input logic [7:0] w);
		@(posedge clk_sys);
		#1;
		data_in = w;
		{data_wr, cfg_wr, cfg_rd, data_rd, fault_clr, pwm_start} = stb;
		@(posedge clk_sys);
		#1;
		{data_wr, cfg_wr, cfg_rd, data_rd, fault_clr, pwm_start} = 6'h00;
		data_in = ~w;
	endtask
endmodule
`default_nettype wire

// >>> sim/low_side_output_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the sequencer: commands through the host model
module low_side_output_sequencer_tb;
	import lsos_pkg::*;
	logic clk_sys = 1'b0; // System clock
	logic rst_b = 1'b0; // Reset, active low
	logic data_wr, cfg_wr, cfg_rd, data_rd, fault_clr, pwm_start; // Strobes
	logic [7:0] data_in; // Command word
	logic [7:0] oc_det = 8'h00; // Overcurrent detects
	logic [7:0] ol_det = 8'h00; // Open-load detects
	logic thermal_shutdown = 1'b0; // Overtemperature
	logic [7:0] chan_out, shift_load; // Drives and readback word
	logic fault_alarm_n, shift_load_vld; // Alarm and load pulse
	logic [15:0] fault_flags, flags_b; // Fault views of both variants
	logic [15:0] n; // High-cycle count
	int checked = 0; // Comparisons made
	int err_count = 0; // Mismatches seen
	int cyc = 0; // Cycle counter for the hang limit
	always #4 clk_sys = ~clk_sys;
	lsos_host u_host (.clk_sys, .data_wr, .cfg_wr, .cfg_rd, .data_rd,
		.fault_clr, .pwm_start, .data_in);
	lsos_sequencer u_dut (.clk_sys, .rst_b, .data_wr, .data_in, .cfg_wr,
		.cfg_rd, .data_rd, .fault_clr, .pwm_start, .oc_det, .ol_det,
		.thermal_shutdown, .chan_out, .fault_alarm_n, .fault_flags,
		.shift_load, .shift_load_vld);
	// Variant without open-load detection
	lsos_sequencer #(.HAS_OPEN_LOAD(1'b0)) u_dut_b (.clk_sys, .rst_b,
		.data_wr, .data_in, .cfg_wr, .cfg_rd, .data_rd, .fault_clr,
		.pwm_start, .oc_det, .ol_det, .thermal_shutdown, .chan_out(),
		.fault_alarm_n(), .fault_flags(flags_b), .shift_load(),
		.shift_load_vld());
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] w);
		u_host.send(6'h20, w);
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic cfg(input logic [7:0] w);
		u_host.send(6'h10, w);
	endtask
	// Readback word stands in the cycle after the strobe edge
	task automatic rd(input logic [5:0] stb, input logic [7:0] e);
		u_host.send(stb, 8'h00);
		#1;
		chk("shift_load_vld", 16'h0001, {15'h0000, shift_load_vld});
		chk("shift_load", {8'h00, e}, {8'h00, shift_load});
	endtask
	// High cycles of channel zero over one PWM period
	task automatic hi();
		n = 16'h0000;
		repeat (PWM_CYC) begin
			@(negedge clk_sys);
			n = n + 16'(chan_out[0]);
		end
	endtask
	// Detect pulse of one cycle, then flags settle
	task automatic det(input logic [7:0] oc, input logic [7:0] ol);
		@(posedge clk_sys);
		#1;
		oc_det = oc;
		ol_det = ol;
		@(posedge clk_sys);
		#1;
		oc_det = 8'h00;
		ol_det = 8'h00;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic print_verdict();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Hang limit
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		wr(8'hA5);
		chk("chan_out", 16'h00A5, {8'h00, chan_out});
		rd(6'h04, 8'hA5);
		wr(8'h00);
		cfg(8'hB1);
		rd(6'h08, 8'hB1);
		wr(8'h01);
		hi();
		chk("energize", 16'(PWM_CYC), n);
		u_host.send(6'h01, 8'h00);
		repeat (4) @(posedge clk_sys);
		hi();
		chk("pwm_start", 16'(3 * SLOT_CYC), n);
		for (int d = 0; d < 8; d++) begin
			wr(8'h00);
			chk("off", 16'h0000, {8'h00, chan_out});
			cfg({1'b1, 3'(d), 4'h0});
			wr(8'h01);
			hi();
			chk("duty", 16'(d * SLOT_CYC), n);
		end
		cfg(8'h00);
		wr(8'hFF);
		thermal_shutdown = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("thermal", 16'h0000, {8'h00, chan_out});
		thermal_shutdown = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("thermal_end", 16'h00FF, {8'h00, chan_out});
		det(8'h04, 8'h20);
		chk("fault_flags", 16'h0420, fault_flags);
		chk("fault_alarm_n", 16'h0000, {15'h0000, fault_alarm_n});
		chk("flags_b", 16'h0400, flags_b);
		u_host.send(6'h02, 8'h00);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("fault_clr", 16'h0000, fault_flags);
		chk("alarm_clr", 16'h0001, {15'h0000, fault_alarm_n});
		det(8'h01, 8'h02);
		chk("flags_set", 16'h0102, fault_flags);
		wr(8'hFE);
		chk("flags_wr", 16'h0000, fault_flags);
		print_verdict();
	end
endmodule
`default_nettype wire
